// >>> pkg/adc_ctrl_pkg.sv
// Register indices, field positions, reset values and timing counts of the converter control
package adc_ctrl_pkg;
   // Register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_CLOCK_DIV = 8'hF2;
   localparam logic [7:0] IDX_CONTROL = 8'hF3;
   localparam logic [7:0] IDX_RESULT_LOW = 8'hF4;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'hF5;
   localparam logic [7:0] IDX_PIN_CONFIG = 8'hF6;
   localparam logic [7:0] IDX_INT_ENABLE = 8'hF7;
   // Control register field positions
   localparam int CTL_CHAN_LSB = 0;
   localparam int CTL_START = 3;
   localparam int CTL_EOC = 4;
   localparam int CTL_ENABLE = 5;
   localparam int CTL_PRECISION_IDLE_BIT = 6;
   // Interrupt enable register field positions
   localparam int IEN_CONVERTER = 1;
   localparam int IEN_GLOBAL = 7;
   // Reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [4:0] RST_CLOCK_DIV = 5'h00;
   localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
   localparam logic [9:0] RST_RESULT = 10'h000;
   // Timing counts in converter clock periods and peripheral clocks
   localparam logic [3:0] CONV_PERIODS = 4'hB;
   localparam logic [3:0] SAMPLE_PERIODS = 4'h1;
   localparam logic [6:0] DIV_FOR_ZERO = 7'h40;
   // Result width and bits kept in standard mode
   localparam int RESULT_BITS = 10;
   localparam int STANDARD_BITS = 8;
   // Conversion sequencer states
   typedef enum logic [1:0] {
      conv_idle,
      conv_sample,
      conv_bits
   } conv_state_type;
endpackage

// >>> logic/adc_conversion_control.sv
// Converter control: bus registers, prescaler, successive approximation sequencer, CPU halt
`timescale 1ns/1ps
// Function
// R1 - One of eight inputs muxed to converter
// R2 - Standard 8-bit and precision 10-bit modes
// R3 - Precision-idle start halts CPU, peripherals run
// R4 - Precision mode resumes CPU only via interrupt
// R5 - Other interrupts held until conversion ends; code holds them only for a precision-mode conversion
// R6 - Per-channel bit makes pin analog input
// R7 - Start on non-analog channel does nothing
// R8 - Conversion lasts eleven converter clock periods
// R9 - Software waits setup time after enabling
// R10 - Start bit launches, hardware clears on completion
// R11 - End flag set on result, software clears
// R12 - Interrupt request when flag and enable set
// R13 - Software also sets global interrupt enable
// R14 - Three-bit field selects input by index
// R15 - Linear codes, saturating at 000h and 3FFh
// R16 - Prescaler: zero divides 64, else twice
// R17 - Enable cleared gives standby, no conversions
// R18 - Precision-idle clear keeps CPU running
// R19 - Start ignored while busy; channel latched
module adc_conversion_control #(
   parameter int CHANNELS = 8, // Analog inputs on the multiplexer
   parameter int DIV_BITS = 5 // Width of the prescale field
) (
   input wire logic clock, // Peripheral clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic wb_we_i, // Write direction
   input wire logic [9:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Bus acknowledge
   input wire logic comparator_above, // Held input at or above trial level
   output logic [2:0] selected_analog_input, // Multiplexer select
   output logic [9:0] trial_code, // Trial level for the comparator
   output logic sample_hold, // Sample phase of the converter
   output logic converter_standby, // Low-power standby of the analog part
   output logic [7:0] analog_pin_config, // Pins given over to analog use
   output logic converter_irq, // End-of-conversion interrupt request
   output logic cpu_halt, // Freeze instruction execution
   output logic hold_other_irqs // Defer other interrupt service
);

   // Elaboration check of parameters the logic can serve
   // Other counts would need a wider multiplexer and prescaler
   if (CHANNELS != 8 || DIV_BITS != 5) begin : param_check
      $error("adc_conversion_control supports eight channels and a 5-bit prescaler");
   end

   // Bus decode
   logic bus_req; // Request seen this cycle
   logic wr_lane0; // Write hitting the low byte lane
   logic [7:0] reg_index; // Register index from byte address
   // Register state
   // Reserved bit seven of control is never stored
   logic [6:0] control_q; // Control bits below the reserved bit
   logic [4:0] clock_div_q; // Prescale value
   logic [7:0] pin_config_q; // Analog pin configuration
   logic int_enable_q; // Converter interrupt enable
   logic global_enable_q; // Global interrupt enable
   logic [9:0] result_q; // Conversion result
   // Sequencer state
   adc_ctrl_pkg::conv_state_type state_q; // Sequencer state
   logic [2:0] chan_latched_q; // Channel held for the whole conversion
   logic precision_q; // Conversion runs in precision mode
   logic [6:0] div_count_q; // Prescaler count within one period
   logic [3:0] period_q; // Converter periods done
   logic [9:0] sar_q; // Bits decided so far
   logic [9:0] bit_mask_q; // Bit under trial
   logic halt_q; // CPU frozen
   logic ack_q; // Registered acknowledge
   logic [31:0] rdata_q; // Registered read data
   // Events
   logic start_write; // Software asks for a conversion
   logic start_ok; // Start accepted
   logic period_end; // Last peripheral clock of a converter period
   logic conv_done; // Result ready this cycle
   logic eoc_clear; // Software clears the end flag
   logic disable_write; // Software switches the converter off
   logic [6:0] div_total; // Peripheral clocks per converter period

   // Prescale division: zero means 64, else twice the value
   function automatic logic [6:0] divide_ratio(input logic [4:0] converter_clock_divider);
      if (converter_clock_divider == 5'h00) begin
         divide_ratio = adc_ctrl_pkg::DIV_FOR_ZERO; // R16
      end else begin
         divide_ratio = {1'b0, converter_clock_divider, 1'b0}; // R16
      end
   endfunction

   // Standard mode keeps only the upper bits of the result
   function automatic logic [9:0] mode_result(input logic [9:0] raw, input logic precise);
      if (precise) begin
         mode_result = raw; // R2
      end else begin
         mode_result = {raw[9:2], 2'b00}; // R2
      end
   endfunction

   // Request decode and write conditions
   // Ack is registered, so a request is answered on the next edge; masking
   // with ack_q keeps a request that is still held from being taken twice
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
   assign reg_index = wb_adr_i[9:2];
   // Peripheral clocks per converter period follow the prescale register
   assign div_total = divide_ratio(clock_div_q);

   // Start request from a control write
   assign start_write = wr_lane0 && reg_index == adc_ctrl_pkg::IDX_CONTROL &&
                        wb_dat_i[adc_ctrl_pkg::CTL_START];
   // Start needs idle, enable and an analog pin on the chosen channel
   // Enable and channel come from the written byte itself, so one write can
   // switch on and launch; a set reserved top bit refuses the start
   assign start_ok = start_write && state_q == adc_ctrl_pkg::conv_idle && // R19
                     wb_dat_i[adc_ctrl_pkg::CTL_ENABLE] && // R17
                     wb_dat_i[adc_ctrl_pkg::CTL_PRECISION_IDLE_BIT + 1] == 1'b0 &&
                     pin_config_q[wb_dat_i[2:0]]; // R7
   // Period ends on the last peripheral clock of a converter period
   assign period_end = state_q != adc_ctrl_pkg::conv_idle && div_count_q == div_total - 7'h01;
   // Done on the last clock of the tenth bit period
   assign conv_done = state_q == adc_ctrl_pkg::conv_bits && period_end &&
                      period_q == adc_ctrl_pkg::CONV_PERIODS - 4'h1; // R8
   // Software clear of the end flag by writing zero
   assign eoc_clear = wr_lane0 && reg_index == adc_ctrl_pkg::IDX_CONTROL &&
                      !wb_dat_i[adc_ctrl_pkg::CTL_EOC];
   // Software clearing the enable bit aborts any conversion at once
   assign disable_write = wr_lane0 && reg_index == adc_ctrl_pkg::IDX_CONTROL &&
                          !wb_dat_i[adc_ctrl_pkg::CTL_ENABLE]; // R17

   // Bus acknowledge, one cycle after the request
   // Ack drops the cycle after it is given, since the request is then masked
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req;
      end
   end

   // Read data mux, unmapped reads as zero
   // Result splits as its high eight bits and its low two bits
   // Interrupt enable reads back only its two defined bits
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_req) begin
         unique case (reg_index)
            adc_ctrl_pkg::IDX_CONTROL: begin
               rdata_q <= {25'h000_0000, control_q}; // R10
            end
            adc_ctrl_pkg::IDX_CLOCK_DIV: begin
               rdata_q <= {27'h000_0000, clock_div_q};
            end
            adc_ctrl_pkg::IDX_PIN_CONFIG: begin
               rdata_q <= {24'h00_0000, pin_config_q};
            end
            adc_ctrl_pkg::IDX_RESULT_HIGH: begin
               rdata_q <= {24'h00_0000, result_q[9:2]};
            end
            adc_ctrl_pkg::IDX_RESULT_LOW: begin
               rdata_q <= {30'h0000_0000, result_q[1:0]};
            end
            adc_ctrl_pkg::IDX_INT_ENABLE: begin
               rdata_q <= {24'h00_0000, global_enable_q, 5'h00, int_enable_q, 1'b0};
            end
            default: begin
               rdata_q <= 32'h0000_0000; // Unmapped
            end
         endcase
      end
   end

   // Control register: mode, enable, channel, start and end flag
   // Start bit reads one only while the sequencer runs
   always_ff @(posedge clock) begin
      if (!resetn) begin
         control_q <= adc_ctrl_pkg::RST_CONTROL[6:0];
      end else begin
         // Software fields
         if (wr_lane0 && reg_index == adc_ctrl_pkg::IDX_CONTROL) begin
            control_q[adc_ctrl_pkg::CTL_PRECISION_IDLE_BIT] <= wb_dat_i[adc_ctrl_pkg::CTL_PRECISION_IDLE_BIT]; // R18
            control_q[adc_ctrl_pkg::CTL_ENABLE] <= wb_dat_i[adc_ctrl_pkg::CTL_ENABLE]; // R17
            control_q[2:0] <= wb_dat_i[2:0]; // R14
         end
         // Start bit stands while converting
         if (start_ok) begin
            control_q[adc_ctrl_pkg::CTL_START] <= 1'b1; // R10
         end else if (conv_done || state_q == adc_ctrl_pkg::conv_idle) begin
            control_q[adc_ctrl_pkg::CTL_START] <= 1'b0; // R10
         end
         // End flag: hardware set wins over software clear
         if (conv_done) begin
            control_q[adc_ctrl_pkg::CTL_EOC] <= 1'b1; // R11
         end else if (eoc_clear) begin
            control_q[adc_ctrl_pkg::CTL_EOC] <= 1'b0; // R11
         end
      end
   end

   // Prescaler, pin configuration and interrupt enables
   always_ff @(posedge clock) begin
      if (!resetn) begin
         clock_div_q <= adc_ctrl_pkg::RST_CLOCK_DIV;
         pin_config_q <= adc_ctrl_pkg::RST_PIN_CONFIG;
         int_enable_q <= 1'b0;
         global_enable_q <= 1'b0;
      end else if (wr_lane0) begin
         if (reg_index == adc_ctrl_pkg::IDX_CLOCK_DIV) begin
            clock_div_q <= wb_dat_i[4:0]; // R16
         end
         if (reg_index == adc_ctrl_pkg::IDX_PIN_CONFIG) begin
            pin_config_q <= wb_dat_i[7:0]; // R6
         end
         if (reg_index == adc_ctrl_pkg::IDX_INT_ENABLE) begin
            int_enable_q <= wb_dat_i[adc_ctrl_pkg::IEN_CONVERTER]; // R12
            global_enable_q <= wb_dat_i[adc_ctrl_pkg::IEN_GLOBAL]; // R13
         end
      end
   end

   // Conversion sequencer: sample period then ten bit periods
   // Period count stands at one when the first bit period begins
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q <= adc_ctrl_pkg::conv_idle;
         period_q <= 4'h0;
      end else if ((!control_q[adc_ctrl_pkg::CTL_ENABLE] || disable_write) &&
                   state_q != adc_ctrl_pkg::conv_idle) begin
         // Abort at once, so standby never overlaps a running conversion
         state_q <= adc_ctrl_pkg::conv_idle; // R17
         period_q <= 4'h0;
      end else begin
         unique case (state_q)
            adc_ctrl_pkg::conv_idle: begin
               period_q <= 4'h0;
               // An accepted start write opens the sample period
               if (start_ok) begin
                  state_q <= adc_ctrl_pkg::conv_sample; // R10
               end
            end
            adc_ctrl_pkg::conv_sample: begin
               if (period_end) begin
                  period_q <= adc_ctrl_pkg::SAMPLE_PERIODS; // R8
                  state_q <= adc_ctrl_pkg::conv_bits;
               end
            end
            adc_ctrl_pkg::conv_bits: begin
               if (conv_done) begin
                  state_q <= adc_ctrl_pkg::conv_idle; // R8
               end else if (period_end) begin
                  period_q <= period_q + 4'h1;
               end
            end
         endcase
      end
   end

   // Prescaler count, restarted at each start
   // Restarting at every period end keeps all periods equal
   always_ff @(posedge clock) begin
      if (!resetn) begin
         div_count_q <= 7'h00;
      end else if (state_q == adc_ctrl_pkg::conv_idle || period_end) begin
         div_count_q <= 7'h00; // R16
      end else begin
         div_count_q <= div_count_q + 7'h01;
      end
   end

   // Channel and mode latched at start of the sample phase
   // Later channel writes leave a running conversion alone
   always_ff @(posedge clock) begin
      if (!resetn) begin
         chan_latched_q <= 3'h0;
         precision_q <= 1'b0;
      end else if (start_ok) begin
         chan_latched_q <= wb_dat_i[2:0]; // R19
         precision_q <= wb_dat_i[adc_ctrl_pkg::CTL_PRECISION_IDLE_BIT]; // R2
      end
   end

   // Successive approximation from the top bit down
   // Mask walks one place right per bit period; ten periods empty it
   always_ff @(posedge clock) begin
      if (!resetn) begin
         sar_q <= 10'h000;
         bit_mask_q <= 10'h000;
      end else if (start_ok) begin
         sar_q <= 10'h000;
         bit_mask_q <= 10'h200;
      end else if (state_q == adc_ctrl_pkg::conv_bits && period_end) begin
         // Keep the trial bit if the input is at or above it
         if (comparator_above) begin
            sar_q <= sar_q | bit_mask_q; // R15
         end
         bit_mask_q <= {1'b0, bit_mask_q[9:1]};
      end
   end

   // Result register loaded as the end flag sets
   // The last trial bit is decided at the same edge that loads the result
   always_ff @(posedge clock) begin
      if (!resetn) begin
         result_q <= adc_ctrl_pkg::RST_RESULT;
      end else if (conv_done) begin
         result_q <= mode_result(comparator_above ? (sar_q | bit_mask_q) : sar_q,
                                 precision_q); // R11
      end
   end

   // CPU freeze in precision mode, released by the interrupt
   // With the converter interrupt masked the CPU stays frozen, so software
   // must enable it before a precision start
   always_ff @(posedge clock) begin
      if (!resetn) begin
         halt_q <= 1'b0;
      end else if (start_ok) begin
         halt_q <= wb_dat_i[adc_ctrl_pkg::CTL_PRECISION_IDLE_BIT]; // R3 R18
      end else if (converter_irq) begin
         halt_q <= 1'b0; // R4
      end
   end

   // Outputs
   // Trial level rests at zero outside the bit phase
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign selected_analog_input = chan_latched_q; // R1 R14
   assign trial_code = state_q == adc_ctrl_pkg::conv_bits ? (sar_q | bit_mask_q) : 10'h000;
   assign sample_hold = state_q == adc_ctrl_pkg::conv_sample; // R8
   assign converter_standby = !control_q[adc_ctrl_pkg::CTL_ENABLE]; // R17
   assign analog_pin_config = pin_config_q; // R6
   assign converter_irq = control_q[adc_ctrl_pkg::CTL_EOC] && int_enable_q &&
                          global_enable_q; // R12
   assign cpu_halt = halt_q; // R3
   assign hold_other_irqs = precision_q && state_q != adc_ctrl_pkg::conv_idle; // R5

endmodule

// >>> dv/adc_conversion_control_monitor.sv
// Port-level checks on the converter control block
`timescale 1ns/1ps
module adc_conversion_control_monitor (
   input wire logic clock,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [2:0] selected_analog_input,
   input wire logic [9:0] trial_code,
   input wire logic sample_hold,
   input wire logic converter_standby,
   input wire logic converter_irq,
   input wire logic cpu_halt,
   input wire logic hold_other_irqs
);
   // One clock domain, reset disables every check
   default clocking mon_cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // Bus request answered on the next cycle
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   // Acknowledge is a single-cycle pulse
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held longer than one cycle");
   // Standby means no sampling, no trial level and no held interrupts
   standby_quiet_a: assert property (converter_standby
      |-> !sample_hold && trial_code == 10'h000 && !hold_other_irqs)
      else $error("activity while in standby");
   // No trial level during the sample period
   sample_trial_a: assert property (sample_hold |-> trial_code == 10'h000)
      else $error("trial level driven while sampling");
   // Channel held steady once sampling runs
   chan_latched_a: assert property (sample_hold && $past(sample_hold)
      |-> $stable(selected_analog_input))
      else $error("channel moved during sampling");
   // CPU freed only by the end-of-conversion request
   halt_release_a: assert property ($fell(cpu_halt) |-> $past(converter_irq))
      else $error("cpu released without converter request");
   // Freezing the CPU also defers other requests
   halt_start_a: assert property ($rose(cpu_halt) |-> hold_other_irqs)
      else $error("cpu frozen without deferring other requests");
   // Request appears only with the sequencer idle
   irq_at_end_a: assert property ($rose(converter_irq)
      |-> !sample_hold && trial_code == 10'h000)
      else $error("request raised mid conversion");
   // Main scenarios reached
   cover property ($rose(cpu_halt));
   cover property ($rose(converter_irq));
   cover property ($fell(sample_hold));
   cover property ($rose(converter_standby));
endmodule

// >>> dv/adc_conversion_control_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_bench;
   // Channel, precision, held level, expected result
   typedef struct packed {logic [2:0] ch; logic pi; logic [9:0] vin; logic [9:0] res;} row_type;
   logic clock = 1'h0;
   logic resetn = 1'h0; // Reset, active low
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [9:0] wb_adr_i = 10'h000;
   logic [3:0] wb_sel_i = 4'hF; // All lanes on
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, sample_hold, converter_standby, converter_irq, cpu_halt, hold_other_irqs;
   logic [2:0] selected_analog_input;
   logic [9:0] trial_code;
   logic [7:0] analog_pin_config;
   logic [7:0] rd; // Last read byte
   logic [4:0] snap; // Halt, hold, channel just after a start
   logic [9:0] vin = 10'h000; // Held analog level as a code
   wire logic comparator_above = (vin >= trial_code); // Ideal comparator
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int n;
   // Every channel, both modes, both ends of the range
   row_type rows [8] = '{'{3'h0, 1'h1, 10'h3FF, 10'h3FF}, '{3'h1, 1'h0, 10'h3FF, 10'h3FC},
      '{3'h2, 1'h1, 10'h000, 10'h000}, '{3'h3, 1'h0, 10'h155, 10'h154},
      '{3'h4, 1'h1, 10'h2AA, 10'h2AA}, '{3'h5, 1'h0, 10'h203, 10'h200},
      '{3'h6, 1'h1, 10'h1FF, 10'h1FF}, '{3'h7, 1'h0, 10'h0FF, 10'h0FC}};
   adc_conversion_control dut (.clock, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .comparator_above, .selected_analog_input,
      .trial_code, .sample_hold, .converter_standby, .analog_pin_config, .converter_irq,
      .cpu_halt, .hold_other_irqs);
   // Free-running clock
   initial begin
      forever #2.5 clock = ~clock;
   end
   // Verdict and end of run
   task end_sim;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end
   // Compare seen against expected
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic bus cycle; read byte lands in rd
   task wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clock);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'h0};
      wb_dat_i <= {24'h0, d};
      @(posedge clock);
      while (wb_ack_o !== 1'h1) @(posedge clock);
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask
   // Counts cycles from the end of the last bus cycle to the request
   task wait_irq(output int cnt);
      cnt = 0;
      @(negedge clock);
      snap = {cpu_halt, hold_other_irqs, selected_analog_input};
      while (converter_irq !== 1'h1 && cnt < 2000) begin
         @(negedge clock);
         cnt++;
      end
      // A request that never comes is a mismatch
      if (cnt == 2000) begin
         errors++;
         end_sim();
      end
   endtask
   initial begin
      repeat (2) @(posedge clock);
      resetn <= 1'h1;
      @(negedge clock);
      chk(converter_standby, 1'h1);
      wb(1'h0, 8'hF3, 8'h00);
      chk(rd, 8'h00);
      wb(1'h1, 8'hF6, 8'hFF);
      chk(analog_pin_config, 8'hFF);
      wb(1'h1, 8'hF2, 8'h01);
      wb(1'h1, 8'hF7, 8'h82);
      wb(1'h1, 8'hF3, 8'h20);
      repeat (10) @(posedge clock);
      $display("reset and setup done");
      // Table of conversions, two clocks per converter period
      foreach (rows[i]) begin
         vin <= rows[i].vin;
         wb(1'h1, 8'hF3, {1'h0, rows[i].pi, 3'h5, rows[i].ch});
         wait_irq(n);
         chk(snap, {rows[i].pi, rows[i].pi, rows[i].ch});
         chk(n, 21);
         wb(1'h0, 8'hF5, 8'h00);
         chk(rd, rows[i].res[9:2]);
         wb(1'h0, 8'hF4, 8'h00);
         chk(rd, {6'h0, rows[i].res[1:0]});
         wb(1'h0, 8'hF3, 8'h00);
         chk(rd[4:3], 2'h2);
         wb(1'h1, 8'hF3, 8'h20);
         @(negedge clock);
         chk(converter_irq, 1'h0);
         $display("row %0d done", i);
         @(posedge clock);
      end
      // Second start while busy is dropped
      vin <= 10'h100;
      wb(1'h1, 8'hF3, 8'h29);
      wb(1'h1, 8'hF3, 8'h2A);
      @(negedge clock);
      chk(selected_analog_input, 3'h1);
      wait_irq(n);
      chk(n, 17);
      wb(1'h0, 8'hF5, 8'h00);
      chk(rd, 8'h40);
      wb(1'h1, 8'hF3, 8'h20);
      $display("busy start done");
      // Start on a digital pin, then with the converter off
      wb(1'h1, 8'hF6, 8'hFE);
      wb(1'h1, 8'hF3, 8'h28);
      wb(1'h0, 8'hF3, 8'h00);
      chk(rd, 8'h20);
      wb(1'h1, 8'hF6, 8'hFF);
      wb_sel_i <= 4'hE; // Low lane off: the write is dropped
      wb(1'h1, 8'hF6, 8'h00);
      wb_sel_i <= 4'hF;
      chk(analog_pin_config, 8'hFF);
      wb(1'h1, 8'hF3, 8'h0B);
      wb(1'h0, 8'hF3, 8'h00);
      chk(rd, 8'h03);
      chk(converter_standby, 1'h1);
      $display("refused starts done");
      // Clearing the enable mid-conversion aborts with no result
      wb(1'h1, 8'hF3, 8'h20);
      repeat (10) @(posedge clock);
      wb(1'h1, 8'hF3, 8'h28);
      wb(1'h1, 8'hF3, 8'h00);
      wb(1'h0, 8'hF3, 8'h00);
      chk(rd, 8'h00);
      repeat (30) @(posedge clock);
      chk(converter_irq, 1'h0);
      wb(1'h0, 8'hF3, 8'h00);
      chk(rd, 8'h00);
      $display("abort done");
      // Zero prescale gives 64 clocks per period
      wb(1'h1, 8'hF2, 8'h00);
      wb(1'h1, 8'hF3, 8'h20);
      repeat (10) @(posedge clock);
      wb(1'h1, 8'hF3, 8'h28);
      wait_irq(n);
      chk(n, 703);
      wb(1'h1, 8'hF3, 8'h20);
      $display("slow clock done");
      // Masked request, then unmasked, then cleared
      wb(1'h1, 8'hF2, 8'h01);
      wb(1'h1, 8'hF7, 8'h80);
      wb(1'h1, 8'hF3, 8'h28);
      repeat (30) @(posedge clock);
      chk(converter_irq, 1'h0);
      wb(1'h0, 8'hF3, 8'h00);
      chk(rd[4], 1'h1);
      wb(1'h1, 8'hF7, 8'h82);
      @(negedge clock);
      chk(converter_irq, 1'h1);
      wb(1'h1, 8'hF3, 8'h20);
      @(negedge clock);
      chk(converter_irq, 1'h0);
      // Reset in the middle of a precision conversion
      wb(1'h1, 8'hF3, 8'h68);
      chk(cpu_halt, 1'h1);
      resetn <= 1'h0;
      repeat (3) @(posedge clock);
      resetn <= 1'h1;
      @(negedge clock);
      chk({cpu_halt, hold_other_irqs, sample_hold, converter_irq}, 32'h0);
      chk(converter_standby, 1'h1);
      chk(analog_pin_config, 8'h00);
      wb(1'h0, 8'hF3, 8'h00);
      chk(rd, 8'h00);
      $display("mid-run reset done");
      // Unmapped place reads zero
      wb(1'h0, 8'h10, 8'h00);
      chk(wb_dat_o, 32'h0);
      $display("mask and unmapped done");
      end_sim();
   end
endmodule
bind adc_conversion_control adc_conversion_control_monitor mon (.clock(clock),
   .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .selected_analog_input(selected_analog_input), .trial_code(trial_code),
   .sample_hold(sample_hold), .converter_standby(converter_standby),
   .converter_irq(converter_irq), .cpu_halt(cpu_halt), .hold_other_irqs(hold_other_irqs));
